// ---- rtl/tpc_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - compare-A irq requested only with enable, global flag and match flag set.
// - overflow irq requested only with enable, global flag and overflow flag set.
// - when capture register is not top, capture flag sets on a detected event at the chosen capture input.
// - when capture register is top, capture flag sets on reaching top.
// - capture flag clears on vector taken or software writing one.
// - compare flags set one timer tick after counter equals compare value.
// - force-compare strobes never set the compare match flags.
// - compare flags clear on vector taken or software writing one.
// - overflow flag sets on counter overflow; clears on vector or write one.
// - select one counts at the full system clock rate.
// - shared prescaler gives taps at divide 8, 64, 256 and 1024.
// - prescaler runs freely regardless of any timer clock select.
// - prescaler reset restarts the phase for every connected timer.
// - pin synchronised each clock, edge detected; seven rising, six falling.
// - pin edge reaches counter enable within 2 to 3 clocks.
// - external edges drive the counter directly, bypassing the divider.
// - in sync mode the prescaler reset bits hold their written value.
// - clearing sync mode clears the reset bits so timers start together.
// - capture select zero picks first capture pin, one picks second.
// - writing prescaler reset resets it; bit self-clears unless sync mode.
module tpc_top
  import tpc_pkg::*;
(
  input  wire logic       clk,              // 10 mhz i/o clock
  input  wire logic       reset,            // async reset, active high
  input  wire logic [7:0] io_addr,          // register byte address
  input  wire logic       io_wr,            // write strobe
  input  wire logic       io_rd,            // read strobe
  input  wire logic [7:0] io_wdata,         // write data
  output logic      [7:0] io_rdata,         // registered read data
  input  wire logic [2:0] t8_clock_select,  // 8-bit timer clock select
  input  wire logic [2:0] t16_clock_select, // 16-bit timer clock select
  input  wire logic       ext_count_pin_a,  // 8-bit timer count pin
  input  wire logic       ext_count_pin_b,  // 16-bit timer count pin
  input  wire logic       capture_pin_first,  // capture pin 0
  input  wire logic       capture_pin_second, // capture pin 1
  input  wire logic       capture_top_mode, // capture register is top
  input  wire logic       cap_edge_rising,  // capture edge polarity
  input  wire logic       ovf_event,        // counter overflow, normal/ctc
  input  wire logic       top_event,        // counter at top
  input  wire logic       match_a,          // counter equals compare a
  input  wire logic       match_b,          // counter equals compare b
  input  wire logic       force_cmp_a,      // force strobe, flag untouched
  input  wire logic       force_cmp_b,      // force strobe, flag untouched
  input  wire logic       global_irq_en,    // global interrupt flag
  input  wire logic       cmp_a_irq_enable, // compare a irq enable
  input  wire logic       cmp_b_irq_enable, // compare b irq enable
  input  wire logic       overflow_irq_enable, // overflow irq enable
  input  wire logic       capture_irq_enable,  // capture irq enable
  input  wire logic       ack_cap,          // capture vector taken
  input  wire logic       ack_cmp_a,        // compare a vector taken
  input  wire logic       ack_cmp_b,        // compare b vector taken
  input  wire logic       ack_ovf,          // overflow vector taken
  output logic            t8_tick,          // 8-bit timer count enable
  output logic            t16_tick,         // 16-bit timer count enable
  output logic            capture_event,    // capture strobe
  output logic            irq_cmp_a,        // compare a request
  output logic            irq_cmp_b,        // compare b request
  output logic            irq_ovf,          // overflow request
  output logic            irq_cap           // capture request
);
  tpc_src_if src ();

  logic [TPC_PRE_W-1:0] pre_r;
  logic                 sync_mode_r;
  logic                 cap_sel_r;
  logic                 psr_r;
  logic                 async_psr_r;
  logic                 cap_a1_r;
  logic                 cap_a2_r;
  logic                 cap_b1_r;
  logic                 cap_b2_r;
  logic                 cap_prev_r;
  logic                 cap_sync;
  logic                 cap_det;
  logic                 cmpa_pend_r;
  logic                 cmpb_pend_r;
  logic                 flag_cap_r;
  logic                 flag_a_r;
  logic                 flag_b_r;
  logic                 flag_ovf_r;
  logic                 wr_flags;
  logic                 wr_gtc;
  logic [7:0]           rd_nxt;

  // register write strobes by address
  assign wr_flags = io_wr && io_addr == TPC_FLAGS_ADDR;
  assign wr_gtc   = io_wr && io_addr == TPC_GTC_ADDR;

  // general timer control: sync mode, capture select, prescaler resets
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_mode_r <= 1'b0;
      cap_sel_r   <= 1'b0;
      psr_r       <= 1'b0;
      async_psr_r <= 1'b0;
    end else if (wr_gtc) begin
      sync_mode_r <= io_wdata[TPC_BIT_TSM];
      cap_sel_r   <= io_wdata[TPC_BIT_ICSEL];
      // reset bits kept only while sync mode is written one
      psr_r <= io_wdata[TPC_BIT_PSR] & io_wdata[TPC_BIT_TSM];
      async_psr_r <= io_wdata[TPC_BIT_APSR] & io_wdata[TPC_BIT_TSM];
    end else if (!sync_mode_r) begin
      psr_r       <= 1'b0;
      async_psr_r <= 1'b0;
    end
  end

  // free-running shared prescaler, cleared by reset request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) pre_r <= TPC_PRE_ZERO;
    else if (src.psr_active) pre_r <= TPC_PRE_ZERO;
    else pre_r <= pre_r + TPC_PRE_ONE;
  end

  // taps pulse one cycle each time the low bits roll over
  assign src.psr_active = psr_r | (wr_gtc & io_wdata[TPC_BIT_PSR]);
  assign src.tick1    = 1'b1;
  assign src.tick8    = (pre_r & TPC_TAP8) == TPC_TAP8;
  assign src.tick64   = (pre_r & TPC_TAP64) == TPC_TAP64;
  assign src.tick256  = (pre_r & TPC_TAP256) == TPC_TAP256;
  assign src.tick1024 = (pre_r & TPC_TAP1024) == TPC_TAP1024;

  // one selector per timer sharing the same prescaler
  tpc_clk_sel u_sel8 (
    .clk     (clk),
    .reset   (reset),
    .src     (src),
    .cs      (t8_clock_select),
    .ext_pin (ext_count_pin_a),
    .tick    (t8_tick)
  );
  tpc_clk_sel u_sel16 (
    .clk     (clk),
    .reset   (reset),
    .src     (src),
    .cs      (t16_clock_select),
    .ext_pin (ext_count_pin_b),
    .tick    (t16_tick)
  );

  // capture pin synchronisers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cap_a1_r   <= 1'b0;
      cap_a2_r   <= 1'b0;
      cap_b1_r   <= 1'b0;
      cap_b2_r   <= 1'b0;
      cap_prev_r <= 1'b0;
    end else begin
      cap_a1_r   <= capture_pin_first;
      cap_a2_r   <= cap_a1_r;
      cap_b1_r   <= capture_pin_second;
      cap_b2_r   <= cap_b1_r;
      cap_prev_r <= cap_sync;
    end
  end

  // selected input and its edge
  assign cap_sync = cap_sel_r ? cap_b2_r : cap_a2_r;
  assign cap_det  = cap_edge_rising ? (cap_sync & ~cap_prev_r)
                                    : (~cap_sync & cap_prev_r);

  // capture strobe towards the capture register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) capture_event <= 1'b0;
    else       capture_event <= cap_det & ~capture_top_mode;
  end

  // compare matches held until the next timer tick
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cmpa_pend_r <= 1'b0;
      cmpb_pend_r <= 1'b0;
    end else if (t16_tick) begin
      cmpa_pend_r <= match_a;
      cmpb_pend_r <= match_b;
    end
  end

  // sticky flags: set wins over clear; forced strobes ignored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flag_cap_r <= 1'b0;
      flag_a_r   <= 1'b0;
      flag_b_r   <= 1'b0;
      flag_ovf_r <= 1'b0;
    end else begin
      if ((capture_top_mode ? top_event : cap_det))
        flag_cap_r <= 1'b1;
      else if (ack_cap || (wr_flags && io_wdata[TPC_BIT_CAP]))
        flag_cap_r <= 1'b0;
      if (cmpa_pend_r && t16_tick)
        flag_a_r <= 1'b1;
      else if (ack_cmp_a || (wr_flags && io_wdata[TPC_BIT_CMPA]))
        flag_a_r <= 1'b0;
      if (cmpb_pend_r && t16_tick)
        flag_b_r <= 1'b1;
      else if (ack_cmp_b || (wr_flags && io_wdata[TPC_BIT_CMPB]))
        flag_b_r <= 1'b0;
      if (ovf_event)
        flag_ovf_r <= 1'b1;
      else if (ack_ovf || (wr_flags && io_wdata[TPC_BIT_OVF]))
        flag_ovf_r <= 1'b0;
    end
  end

  // interrupt requests from flags and enables
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_cmp_a <= 1'b0;
      irq_cmp_b <= 1'b0;
      irq_ovf   <= 1'b0;
      irq_cap   <= 1'b0;
    end else begin
      irq_cmp_a <= flag_a_r & cmp_a_irq_enable & global_irq_en;
      irq_cmp_b <= flag_b_r & cmp_b_irq_enable & global_irq_en;
      irq_ovf   <= flag_ovf_r & overflow_irq_enable & global_irq_en;
      irq_cap   <= flag_cap_r & capture_irq_enable & global_irq_en;
    end
  end

  // read mux
  always_comb begin
    rd_nxt = TPC_RESET_VAL;
    if (io_addr == TPC_FLAGS_ADDR) begin
      rd_nxt[TPC_BIT_CAP]  = flag_cap_r;
      rd_nxt[TPC_BIT_CMPB] = flag_b_r;
      rd_nxt[TPC_BIT_CMPA] = flag_a_r;
      rd_nxt[TPC_BIT_OVF]  = flag_ovf_r;
    end else if (io_addr == TPC_GTC_ADDR) begin
      rd_nxt[TPC_BIT_TSM]   = sync_mode_r;
      rd_nxt[TPC_BIT_ICSEL] = cap_sel_r;
      rd_nxt[TPC_BIT_APSR]  = async_psr_r;
      rd_nxt[TPC_BIT_PSR]   = psr_r;
    end
  end

  // registered read data
  always_ff @(posedge clk or posedge reset) begin
    if (reset)      io_rdata <= TPC_RESET_VAL;
    else if (io_rd) io_rdata <= rd_nxt;
  end

  // interrupt request checks
  AST_IRQ_A: assert property (@(posedge clk) disable iff (reset)
    irq_cmp_a |-> $past(flag_a_r && cmp_a_irq_enable && global_irq_en))
    else $error("compare a request without cause");
  AST_IRQ_OVF: assert property (@(posedge clk) disable iff (reset)
    irq_ovf |-> $past(flag_ovf_r && overflow_irq_enable && global_irq_en))
    else $error("overflow request without cause");

  // capture flag and strobe checks
  AST_CAP_SET: assert property (@(posedge clk) disable iff (reset)
    (cap_det && !capture_top_mode) |=> flag_cap_r)
    else $error("capture event lost");
  AST_CAP_EVT: assert property (@(posedge clk) disable iff (reset)
    (cap_det && !capture_top_mode) |=> capture_event)
    else $error("capture strobe missing");
  AST_CAP_TOP: assert property (@(posedge clk) disable iff (reset)
    (capture_top_mode && top_event) |=> flag_cap_r)
    else $error("top did not set capture flag");
  AST_CAP_CLR: assert property (@(posedge clk) disable iff (reset)
    (ack_cap && !(capture_top_mode ? top_event : cap_det)) |=> !flag_cap_r)
    else $error("capture flag not cleared");

  // compare and overflow flag checks
  AST_CMPA_SET: assert property (@(posedge clk) disable iff (reset)
    $rose(flag_a_r) |-> $past(t16_tick && cmpa_pend_r))
    else $error("compare a flag set without match");
  AST_CMPB_SET: assert property (@(posedge clk) disable iff (reset)
    $rose(flag_b_r) |-> $past(t16_tick && cmpb_pend_r))
    else $error("compare b flag set without match");
  AST_CMPA_CLR: assert property (@(posedge clk) disable iff (reset)
    (ack_cmp_a && !(cmpa_pend_r && t16_tick)) |=> !flag_a_r)
    else $error("compare a flag not cleared");
  AST_CMPB_CLR: assert property (@(posedge clk) disable iff (reset)
    (wr_flags && io_wdata[TPC_BIT_CMPB] && !(cmpb_pend_r && t16_tick))
    |=> !flag_b_r)
    else $error("compare b flag not cleared");
  AST_OVF_SET: assert property (@(posedge clk) disable iff (reset)
    ovf_event |=> flag_ovf_r)
    else $error("overflow flag not set");
  AST_OVF_CLR: assert property (@(posedge clk) disable iff (reset)
    (wr_flags && io_wdata[TPC_BIT_OVF] && !ovf_event) |=> !flag_ovf_r)
    else $error("overflow flag not cleared");

  // prescaler checks
  AST_PRE_RUN: assert property (@(posedge clk) disable iff (reset)
    !src.psr_active |=> pre_r == $past(pre_r) + TPC_PRE_ONE)
    else $error("prescaler did not advance");
  AST_TICK_QUIET: assert property (@(posedge clk) disable iff (reset)
    src.psr_active |=> !t8_tick && !t16_tick)
    else $error("count enable during prescaler reset");
  AST_PSR_SELF: assert property (@(posedge clk) disable iff (reset)
    (wr_gtc && io_wdata[TPC_BIT_PSR] && !io_wdata[TPC_BIT_TSM])
    |=> !psr_r && pre_r == TPC_PRE_ZERO)
    else $error("prescaler reset stuck");
  AST_PSR_HOLD: assert property (@(posedge clk) disable iff (reset)
    (sync_mode_r && psr_r && !wr_gtc) |=> psr_r && pre_r == TPC_PRE_ZERO)
    else $error("sync mode lost prescaler reset");
  AST_SYNC_REL: assert property (@(posedge clk) disable iff (reset)
    (wr_gtc && !io_wdata[TPC_BIT_TSM]) |=> !psr_r && !async_psr_r)
    else $error("sync release kept reset bits");
endmodule

// ---- rtl/tpc_pkg.sv ----
package tpc_pkg;
  // register byte offsets on the cpu i/o port
  localparam logic [7:0] TPC_FLAGS_ADDR = 8'h36;
  localparam logic [7:0] TPC_GTC_ADDR   = 8'h43;
  localparam logic [7:0] TPC_RESET_VAL  = 8'h00;
  // flag register bit positions
  localparam int TPC_BIT_OVF = 0;
  localparam int TPC_BIT_CMPA = 1;
  localparam int TPC_BIT_CMPB = 2;
  localparam int TPC_BIT_CAP = 5;
  // general timer control bit positions
  localparam int TPC_BIT_PSR = 0;
  localparam int TPC_BIT_APSR = 1;
  localparam int TPC_BIT_ICSEL = 6;
  localparam int TPC_BIT_TSM = 7;
  // clock select encodings
  localparam logic [2:0] TPC_CS_STOP = 3'h0;
  localparam logic [2:0] TPC_CS_DIV1 = 3'h1;
  localparam logic [2:0] TPC_CS_DIV8 = 3'h2;
  localparam logic [2:0] TPC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TPC_CS_DIV256 = 3'h4;
  localparam logic [2:0] TPC_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TPC_CS_EXTFALL = 3'h6;
  localparam logic [2:0] TPC_CS_EXTRISE = 3'h7;
  // prescaler width and tap masks (count low bits all ones)
  localparam int TPC_PRE_W = 10;
  localparam logic [9:0] TPC_TAP8 = 10'h007;
  localparam logic [9:0] TPC_TAP64 = 10'h03f;
  localparam logic [9:0] TPC_TAP256 = 10'h0ff;
  localparam logic [9:0] TPC_TAP1024 = 10'h3ff;
  localparam logic [9:0] TPC_PRE_ONE = 10'h001;
  localparam logic [9:0] TPC_PRE_ZERO = 10'h000;
endpackage

// ---- rtl/tpc_src_if.sv ----
`timescale 1ns/1ps
// shared prescaler taps handed to each clock-select channel
interface tpc_src_if;
  logic tick1;
  logic tick8;
  logic tick64;
  logic tick256;
  logic tick1024;
  logic psr_active;
  modport pre (output tick1, tick8, tick64, tick256, tick1024, psr_active);
  modport sel (input tick1, tick8, tick64, tick256, tick1024, psr_active);
endinterface

// ---- rtl/tpc_clk_sel.sv ----
`timescale 1ns/1ps
// one timer's clock-source selector and external-pin edge detector
module tpc_clk_sel
  import tpc_pkg::*;
(
  input  wire logic       clk,      // system clock
  input  wire logic       reset,    // async reset
  tpc_src_if.sel          src,      // prescaler taps
  input  wire logic [2:0] cs,       // clock select field
  input  wire logic       ext_pin,  // raw external count pin
  output logic            tick      // one-cycle count enable
);
  logic sync1_r;
  logic sync2_r;
  logic edge_r;
  logic tick_nxt;

  // two-stage pin synchroniser then edge history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      edge_r  <= 1'b0;
    end else begin
      sync1_r <= ext_pin;
      sync2_r <= sync1_r;
      edge_r  <= sync2_r;
    end
  end

  // source multiplexer; external edges bypass the divider
  always_comb begin
    unique case (cs)
      TPC_CS_STOP:    tick_nxt = 1'b0;
      TPC_CS_DIV1:    tick_nxt = src.tick1;
      TPC_CS_DIV8:    tick_nxt = src.tick8;
      TPC_CS_DIV64:   tick_nxt = src.tick64;
      TPC_CS_DIV256:  tick_nxt = src.tick256;
      TPC_CS_DIV1024: tick_nxt = src.tick1024;
      TPC_CS_EXTFALL: tick_nxt = edge_r & ~sync2_r;
      TPC_CS_EXTRISE: tick_nxt = ~edge_r & sync2_r;
    endcase
  end

  // registered enable, pin edge to count in about three cycles
  always_ff @(posedge clk or posedge reset) begin
    if (reset) tick <= 1'b0;
    else       tick <= tick_nxt & ~src.psr_active;
  end

  AST_EXT_RISE: assert property (@(posedge clk) disable iff (reset)
    (cs == TPC_CS_EXTRISE && $rose(sync2_r) && !src.psr_active) |=> tick)
    else $error("rising pin edge gave no count");
  AST_STOP_QUIET: assert property (@(posedge clk) disable iff (reset)
    $past(cs) == TPC_CS_STOP |-> !tick)
    else $error("stopped channel counted");
endmodule

// ---- sim/tpc_pin_model.sv ----
`timescale 1ns/1ps
// board side: external count clocks and capture triggers
module tpc_pin_model (
  input  wire logic clk,        // system clock
  output logic      pin_a,      // 8-bit timer count pin
  output logic      pin_b,      // 16-bit timer count pin
  output logic      cap_first,  // first capture pin
  output logic      cap_second  // second capture pin
);
  // pins idle low until a frame is asked for
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    cap_first = 1'b0;
    cap_second = 1'b0;
  end

  // n periods, each half held two clocks or more, ends low and stable
  task automatic edges(input bit sel_b, input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      if (sel_b) pin_b = ~i[0];
      else pin_a = ~i[0];
      repeat (half) @(posedge clk);
      #1;
    end
  endtask

  // one capture trigger, high for three clocks
  task automatic cap_pulse(input bit second);
    if (second) cap_second = 1'b1;
    else cap_first = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cap_first = 1'b0;
    cap_second = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import tpc_pkg::*;
  logic       clk = 1'b0, reset = 1'b1, io_wr = 1'b0, io_rd = 1'b0;
  logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, rd_v;
  logic [2:0] cs8 = TPC_CS_STOP, cs16 = TPC_CS_STOP;
  logic       cap_top = 0, ovf_ev = 0, top_ev = 0, m_a = 0, m_b = 0;
  logic       f_a = 0, f_b = 0, gie = 0, en_a = 0, en_b = 0, en_o = 0;
  logic       en_c = 0, ak_c = 0, ak_a = 0, ak_b = 0, ak_o = 0, cap_rise = 1;
  logic       t8_tick, t16_tick, cap_ev, irq_a, irq_b, irq_o, irq_c;
  logic       p_a, p_b, c_1, c_2;
  logic [2:0] sel_t [5] = '{TPC_CS_DIV1, TPC_CS_DIV8, TPC_CS_DIV64,
                            TPC_CS_DIV256, TPC_CS_DIV1024};
  int         div_t [5] = '{1, 8, 64, 256, 1024};
  int         mismatches = 0, n_tests = 0, cnt8 = 0, cnt16 = 0, ncap = 0;
  int         c, n, c8, c16, c8a, c16a;

  always #50 clk = ~clk;
  // count enables sampled away from their launching edge
  always @(negedge clk) begin
    if (t8_tick === 1'b1) cnt8++;
    if (t16_tick === 1'b1) cnt16++;
    if (cap_ev === 1'b1) ncap++;
  end

  tpc_top u_dut (
    .clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .t8_clock_select(cs8), .t16_clock_select(cs16),
    .ext_count_pin_a(p_a), .ext_count_pin_b(p_b),
    .capture_pin_first(c_1), .capture_pin_second(c_2),
    .capture_top_mode(cap_top), .cap_edge_rising(cap_rise),
    .ovf_event(ovf_ev), .top_event(top_ev), .match_a(m_a), .match_b(m_b),
    .force_cmp_a(f_a), .force_cmp_b(f_b), .global_irq_en(gie),
    .cmp_a_irq_enable(en_a), .cmp_b_irq_enable(en_b),
    .overflow_irq_enable(en_o), .capture_irq_enable(en_c),
    .ack_cap(ak_c), .ack_cmp_a(ak_a), .ack_cmp_b(ak_b), .ack_ovf(ak_o),
    .t8_tick(t8_tick), .t16_tick(t16_tick), .capture_event(cap_ev),
    .irq_cmp_a(irq_a), .irq_cmp_b(irq_b), .irq_ovf(irq_o), .irq_cap(irq_c)
  );
  tpc_pin_model u_pin (.clk(clk), .pin_a(p_a), .pin_b(p_b),
                       .cap_first(c_1), .cap_second(c_2));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    cyc(1);
    io_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cyc(1);
    io_addr = a;
    io_rd = 1'b1;
    cyc(1);
    io_rd = 1'b0;
    d = io_rdata;
  endtask
  // negedges from call until the chosen count enable shows
  task automatic wait_tick(input bit w8, output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (((w8 ? t8_tick : t16_tick) !== 1'b1) && k < 3000);
  endtask
  task automatic test_done;
    $display("counts: %0d mismatches, %0d checks", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog for a hung handshake or missing tick
  initial begin
    #(100 * 40000);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(32'hac6a));
    cyc(4);
    reset = 1'b0;
    wr(8'h50, 8'($urandom));
    rd(TPC_FLAGS_ADDR, rd_v);
    chk("flags reset", TPC_RESET_VAL, rd_v);
    rd(TPC_GTC_ADDR, rd_v);
    chk("gtc reset", TPC_RESET_VAL, rd_v);
    rd(8'h50, rd_v);
    chk("unmapped", 8'h00, rd_v);
    $display("registers test done");
    // each tap spacing exact, first count within N+1
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      cs16 = sel_t[i];
      cs8 = 3'($urandom_range(1, 5));
      cyc(1); // let the enable of the old select pass
      wait_tick(0, c);
      chk("first tap", 1, 16'(c <= div_t[i] + 1));
      wait_tick(0, c);
      chk("tap gap", 16'(div_t[i]), 16'(c));
    end
    $display("taps test done");
    // prescaler reset at random phases restarts both timers alike
    cyc(1);
    cs8 = TPC_CS_DIV8;
    cs16 = TPC_CS_DIV64;
    for (int k = 0; k < 2; k++) begin
      cyc($urandom_range(1, 70));
      wr(TPC_GTC_ADDR, 8'h01);
      wait_tick(1, c8);
      wait_tick(0, c16);
      if (k == 0) {c8a, c16a} = {c8, c16};
    end
    chk("t8 phase", 16'(c8a), 16'(c8));
    chk("t16 phase", 16'(c16a), 16'(c16));
    rd(TPC_GTC_ADDR, rd_v);
    chk("reset self clear", 8'h00, rd_v);
    // sync mode keeps the reset bit and halts both timers
    wr(TPC_GTC_ADDR, 8'h81);
    rd(TPC_GTC_ADDR, rd_v);
    chk("sync held", 8'h81, rd_v);
    cnt8 = 0;
    cnt16 = 0;
    cyc(100);
    chk("halted", 0, 16'(cnt8 + cnt16));
    wr(TPC_GTC_ADDR, 8'h00);
    rd(TPC_GTC_ADDR, rd_v);
    chk("sync release", 8'h00, rd_v);
    wait_tick(1, c8);
    wait_tick(0, c16);
    chk("restart", 1, 16'(c8 <= 9 && c8 + c16 <= 66));
    $display("prescaler reset test done");
    // pin edges, rising select then falling select
    for (int k = 0; k < 2; k++) begin
      cyc(1);
      cs8 = k ? TPC_CS_EXTFALL : TPC_CS_EXTRISE;
      cs16 = cs8;
      cyc(2);
      n = $urandom_range(1, 6);
      cnt8 = 0;
      cnt16 = 0;
      fork
        u_pin.edges(1, n, 3);
        wait_tick(0, c);
      join
      u_pin.edges(0, n, 2);
      cyc(4);
      // negedges from pin move to enable; the fall comes three clocks later
      chk("pin edge delay", 16'(k ? 7 : 4), 16'(c));
      chk("pin b count", 16'(n), 16'(cnt16));
      chk("pin a count", 16'(n), 16'(cnt8));
    end
    $display("external clock test done");
    // no timer clock, force strobes: flags stay clear
    cyc(1);
    cs8 = TPC_CS_STOP;
    cs16 = TPC_CS_STOP;
    {m_a, f_a, f_b} = 3'h7;
    cyc(4);
    {m_a, f_a, f_b} = 3'h0;
    rd(TPC_FLAGS_ADDR, rd_v);
    chk("no flag", 8'h00, rd_v);
    cs16 = TPC_CS_DIV1;
    cap_top = 1'b1;
    {ovf_ev, top_ev, m_a, m_b} = 4'hf;
    cyc(1);
    {ovf_ev, top_ev} = 2'h0;
    cyc(2);
    {m_a, m_b} = 2'h0;
    cyc(3);
    rd(TPC_FLAGS_ADDR, rd_v);
    chk("all flags", 8'h27, rd_v);
    for (int g = 0; g < 4; g++) begin
      gie = g[1];
      {en_a, en_b, en_o, en_c} = {4{g[0]}};
      cyc(3);
      chk("irq mask", 16'(g == 3 ? 4'hf : 4'h0),
          16'({irq_a, irq_b, irq_o, irq_c}));
    end
    wr(TPC_FLAGS_ADDR, 8'h05);
    rd(TPC_FLAGS_ADDR, rd_v);
    chk("w1c", 8'h22, rd_v);
    chk("irq follow", 16'h9, 16'({irq_a, irq_b, irq_o, irq_c}));
    {ak_c, ak_a} = 2'h3;
    cyc(1);
    {ak_c, ak_a} = 2'h0;
    rd(TPC_FLAGS_ADDR, rd_v);
    chk("ack clear", 8'h00, rd_v);
    $display("flags test done");
    // capture select honours only the chosen pin
    cap_top = 1'b0;
    gie = 1'b0;
    for (int s = 0; s < 2; s++) begin
      cap_rise = s[0];
      wr(TPC_GTC_ADDR, 8'(s << TPC_BIT_ICSEL));
      ncap = 0;
      u_pin.cap_pulse(~s[0]);
      rd(TPC_FLAGS_ADDR, rd_v);
      chk("other pin", 8'h00, rd_v);
      chk("other strobe", 0, 16'(ncap));
      u_pin.cap_pulse(s[0]);
      rd(TPC_FLAGS_ADDR, rd_v);
      chk("chosen pin", 8'h20, rd_v);
      chk("capture strobe", 1, 16'(ncap));
      wr(TPC_FLAGS_ADDR, 8'h20);
    end
    $display("capture test done");
    test_done();
  end
endmodule
